/* dv/slf_host_model.sv */
`timescale 1ns/100ps
module slf_host_model (
  input wire logic clk_sys, // system clock
  output logic up_wr, // write strobe
  output logic [2:0] up_addr, // port select
  output logic [7:0] up_data, // write data
  input wire logic [7:0] up_rd_data // read data
);
  // ----------------
  // host accesses
  // ----------------
  // idle pins at time zero
  initial
  begin
    up_wr = 1'b0;
    up_addr = 3'h6;
    up_data = 8'h00;
  end

  // one byte, pins set one clock before the strobe, held six clocks after it
  task automatic put(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    up_addr <= a;
    up_data <= d;
    @(posedge clk_sys);
    up_wr <= 1'b1;
    repeat (6) @(posedge clk_sys);
    up_wr <= 1'b0;
    repeat (6) @(posedge clk_sys);
    up_data <= ~d; // stale data is not left on the pins
  endtask

  // holding bytes low first, then the destination
  task automatic write_reg(input logic [7:0] dest, input logic [31:0] w);
    if (dest != 8'h13)
      w[23:18] = 6'h00;
    for (int i = 0; i < 4; i++)
      put(i[2:0], w[8*i +: 8]);
    put(3'h4, dest);
  endtask

  // select a port and sample it once settled
  task automatic read(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    up_addr <= a;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    d = up_rd_data;
  endtask

  // holding bytes untouched until the load is seen done
  task automatic wait_done(output logic ok);
    logic [7:0] v;
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++)
    begin
      read(3'h5, v);
      ok = (v === 8'h01);
    end
  endtask
endmodule

/* dv/testbench.sv */
`timescale 1ns/100ps
module testbench;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic acq_mode = 1'b1;
  logic signed [15:0] err_data = 16'sh0000;
  logic signed [31:0] upper_limit = 32'sh7fffffff;
  logic signed [31:0] lower_limit = 32'sh80000000;
  logic up_wr;
  logic [2:0] up_addr;
  logic [7:0] up_data;
  logic [7:0] up_rd_data;
  logic [31:0] nco_word;
  logic [39:0] lag_acc;
  logic lag_init_done;
  int num_errors = 0;
  int total_checks = 0;
  logic ok;
  logic [7:0] rd;
  logic [39:0] a0;
  logic [3:0] lm [5] = '{4'h0, 4'hf, 4'h8, 4'h1, 4'h0};
  logic [4:0] le [5] = '{5'h00, 5'h04, 5'h0c, 5'h14, 5'h1f};

  // ----------------
  // harness
  // ----------------
  // 250 MHz clock
  always #2 clk_sys = ~clk_sys;

  slf_loop_core slf_loop_core_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .up_wr(up_wr),
    .up_addr(up_addr), .up_data(up_data), .up_rd_data(up_rd_data),
    .acq_mode(acq_mode), .err_data(err_data),
    .upper_limit(upper_limit), .lower_limit(lower_limit),
    .nco_word(nco_word), .lag_acc(lag_acc),
    .lag_init_done(lag_init_done));

  slf_host_model slf_host_model_i (
    .clk_sys(clk_sys), .up_wr(up_wr), .up_addr(up_addr),
    .up_data(up_data), .up_rd_data(up_rd_data));

  // compare and count
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // counts and verdict
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // load the lag accumulator and wait for the done flag
  task automatic load_lag(input logic [31:0] w);
    err_data <= 16'sh0000;
    slf_host_model_i.write_reg(8'h13, w);
    slf_host_model_i.wait_done(ok);
    check({39'h0, ok}, 40'h1);
    check({39'h0, lag_init_done}, 40'h1);
    check(lag_acc, {w, 8'h00});
  endtask

  // growth of the lag accumulator over one compute cycle
  task automatic step(input logic [39:0] d);
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    a0 = lag_acc;
    repeat (8) @(negedge clk_sys);
    check(lag_acc - a0, d);
  endtask

  // ----------------
  // tests
  // ----------------
  // main sequence
  initial
  begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    slf_host_model_i.read(3'h5, rd);
    check({32'h0, rd}, 40'h0);
    load_lag(32'h12345678);
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    check({8'h0, nco_word}, 40'h1234567800 >> 8);
    $display("test lag load done");
    acq_mode <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      slf_host_model_i.write_reg(8'h12,
        {14'h3fff, 4'h3, 5'h01, lm[i], le[i]});
      err_data <= 16'sh0100;
      step(((48'd256 * (48'd16 + lm[i])) << le[i]) >> 12);
    end
    $display("test track gains done");
    slf_host_model_i.write_reg(8'h11, 32'hff00290c);
    acq_mode <= 1'b1;
    step(40'h1800);
    $display("test acquisition gains done");
    upper_limit <= 32'sh120;
    lower_limit <= 32'shf0;
    load_lag(32'h100);
    @(posedge clk_sys);
    err_data <= 16'sh0100;
    repeat (48) @(posedge clk_sys);
    @(negedge clk_sys);
    check(lag_acc, 40'h12000);
    check({8'h0, nco_word}, 40'h1120);
    @(posedge clk_sys);
    err_data <= -16'sh0100;
    repeat (64) @(posedge clk_sys);
    @(negedge clk_sys);
    check(lag_acc, 40'hf000);
    check({8'h0, nco_word}, 40'hfffff0f0);
    $display("test limits done");
    report_and_stop();
  end

  // watchdog
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    report_and_stop();
  end
endmodule

/* rtl/slf_defines.svh */
`ifndef SLF_DEFINES_SVH
`define SLF_DEFINES_SVH

// ----------------------------------------------------------------
// destination addresses and host port selects
// ----------------------------------------------------------------
`define SLF_DEST_GAIN_ACQ 8'h11
`define SLF_DEST_GAIN_TRK 8'h12
`define SLF_DEST_LAG_INIT 8'h13
`define SLF_PORT_DEST 3'h4
`define SLF_PORT_STATUS 3'h5

// ----------------------------------------------------------------
// gain register field positions
// ----------------------------------------------------------------
`define SLF_LEAD_MANT_MSB 17
`define SLF_LEAD_MANT_LSB 14
`define SLF_LEAD_EXP_MSB 13
`define SLF_LEAD_EXP_LSB 9
`define SLF_LAG_MANT_MSB 8
`define SLF_LAG_MANT_LSB 5
`define SLF_LAG_EXP_MSB 4
`define SLF_LAG_EXP_LSB 0
`define SLF_GAIN_RST 18'h00000

// ----------------------------------------------------------------
// loop timing and accumulator shape
// ----------------------------------------------------------------
`define SLF_COMPUTE_CYCLES 8
`define SLF_CNT_LAST 3'h7
`define SLF_CNT_PRE_LAST 3'h6
`define SLF_ACC_FRAC_ZERO 8'h00
`define SLF_ACC_RST 40'h0000000000

`endif

/* rtl/slf_gain_scale.sv */
`timescale 1ns/100ps
module slf_gain_scale (
  input wire logic clk_sys, // system clock
  input wire logic sys_rst, // synchronous reset, active high
  slf_term_if.calc t // error in, scaled terms out
);

  // ----------------------------------------------------------------
  // mantissa with implied one, then power-of-two exponent
  // ----------------------------------------------------------------
  function automatic logic signed [55:0] scale(
    input logic signed [15:0] err,
    input logic [3:0] mant,
    input logic [4:0] expo
  );
    logic signed [21:0] p;
    logic signed [55:0] w;
    p = 22'(err * $signed({2'b01, mant}));
    w = {{34{p[21]}}, p};
    return w <<< expo;
  endfunction

  logic signed [55:0] lead_w;
  logic signed [55:0] lag_w;

  // lead lands on 32-bit word units, lag keeps 8 fraction bits
  assign lead_w = scale(t.err, t.gain.lead_mant, t.gain.lead_exp);
  assign lag_w = scale(t.err, t.gain.lag_mant, t.gain.lag_exp);

  // registered terms
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      t.lead_term <= 32'h00000000;
      t.lag_term <= 40'h0000000000;
    end
    else
    begin
      t.lead_term <= lead_w[51:20];
      t.lag_term <= lag_w[51:12];
    end
  end

  lead_unity_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (t.gain.lead_exp == 5'h14 && t.gain.lead_mant == 4'h0) |=>
    t.lead_term == 32'($past(t.err)) * 32'sh10)
    else $error("lead term wrong at unity gain");

  lag_max_mant_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (t.gain.lag_exp == 5'h0c && t.gain.lag_mant == 4'hf) |=>
    t.lag_term == 40'($past(t.err)) * 40'sh1f)
    else $error("lag term wrong at full mantissa");

  lag_exp_step_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (t.gain.lag_exp == 5'h0d && t.gain.lag_mant == 4'h0) |=>
    t.lag_term == 40'($past(t.err)) * 40'sh20)
    else $error("lag exponent scaling wrong");

endmodule

/* rtl/slf_loop_core.sv */
`timescale 1ns/100ps
`include "slf_defines.svh"
module slf_loop_core (
  input wire logic clk_sys, // system clock, 250 MHz
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic up_wr, // host write strobe pin, active high
  input wire logic [2:0] up_addr, // host port select pin
  input wire logic [7:0] up_data, // host write data pin
  output logic [7:0] up_rd_data, // host read data
  input wire logic acq_mode, // 1 acquisition, 0 track
  input wire logic signed [15:0] err_data, // sampling error
  input wire logic signed [31:0] upper_limit, // lag upper limit
  input wire logic signed [31:0] lower_limit, // lag lower limit
  output logic [31:0] nco_word, // loop filter output
  output logic [39:0] lag_acc, // lag accumulator
  output logic lag_init_done // lag load completed
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [11:0] pin;
  logic [11:0] s1;
  logic [11:0] s2;
  logic [11:0] s3;
  logic [11:0] pin_ok;
  logic wr_q;
  logic wr_evt;

  assign pin = {up_wr, up_addr, up_data};

  // three flops per pin
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      s1 <= 12'h000;
      s2 <= 12'h000;
      s3 <= 12'h000;
    end
    else
    begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a bit changes once the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < 12; gi++)
    begin : g_pin
      always_ff @(posedge clk_sys)
      begin
        if (sys_rst)
          pin_ok[gi] <= 1'b0;
        else if (s2[gi] == s3[gi])
          pin_ok[gi] <= s3[gi];
      end
    end
  endgenerate

  // rising edge of the accepted write strobe
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      wr_q <= 1'b0;
    else
      wr_q <= pin_ok[11];
  end

  assign wr_evt = pin_ok[11] & ~wr_q;

  // ----------------------------------------------------------------
  // holding and gain registers
  // ----------------------------------------------------------------
  logic [7:0] hold [0:3];
  logic [31:0] hold_word;
  logic [17:0] gain_acq;
  logic [17:0] gain_trk;
  logic init_req;
  logic [2:0] wa;
  logic [7:0] wd;

  assign wa = pin_ok[10:8];
  assign wd = pin_ok[7:0];
  assign hold_word = {hold[3], hold[2], hold[1], hold[0]};

  // field split, shared by both gain sets
  function automatic slf_pkg::slf_gain_s fields(input logic [17:0] r);
    slf_pkg::slf_gain_s g;
    g.lead_mant = r[`SLF_LEAD_MANT_MSB:`SLF_LEAD_MANT_LSB];
    g.lead_exp = r[`SLF_LEAD_EXP_MSB:`SLF_LEAD_EXP_LSB];
    g.lag_mant = r[`SLF_LAG_MANT_MSB:`SLF_LAG_MANT_LSB];
    g.lag_exp = r[`SLF_LAG_EXP_MSB:`SLF_LAG_EXP_LSB];
    return g;
  endfunction

  // holding bytes, then transfer by destination address
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < 4; i++)
        hold[i] <= 8'h00;
      gain_acq <= `SLF_GAIN_RST;
      gain_trk <= `SLF_GAIN_RST;
      init_req <= 1'b0;
    end
    else
    begin
      init_req <= 1'b0;
      if (wr_evt && wa < `SLF_PORT_DEST)
        hold[wa[1:0]] <= wd;
      else if (wr_evt && wa == `SLF_PORT_DEST)
      begin
        case (wd)
          `SLF_DEST_GAIN_ACQ: gain_acq <= hold_word[17:0];
          `SLF_DEST_GAIN_TRK: gain_trk <= hold_word[17:0];
          `SLF_DEST_LAG_INIT: init_req <= 1'b1;
          default: init_req <= 1'b0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // compute cycle sequencer
  // ----------------------------------------------------------------
  slf_pkg::slf_phase_e ph;
  slf_pkg::slf_phase_e next_ph;
  logic [2:0] cnt;

  // eight clocks per output
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      cnt <= 3'h0;
    else
      cnt <= cnt + 3'h1;
  end

  always_comb
  begin
    case (ph)
      slf_pkg::SLF_PH_START: next_ph = slf_pkg::SLF_PH_RUN;
      slf_pkg::SLF_PH_RUN:
        next_ph = (cnt == `SLF_CNT_PRE_LAST) ? slf_pkg::SLF_PH_UPDATE :
                  slf_pkg::SLF_PH_RUN;
      slf_pkg::SLF_PH_UPDATE: next_ph = slf_pkg::SLF_PH_START;
      default: next_ph = slf_pkg::SLF_PH_START;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      ph <= slf_pkg::SLF_PH_START;
    else
      ph <= next_ph;
  end

  // ----------------------------------------------------------------
  // gain scaling
  // ----------------------------------------------------------------
  slf_term_if t ();

  slf_gain_scale u_scale (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .t(t.calc)
  );

  // gain set follows mode, error latched at cycle start
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      t.gain <= fields(`SLF_GAIN_RST);
      t.err <= 16'sh0000;
    end
    else
    begin
      t.gain <= acq_mode ? fields(gain_acq) : fields(gain_trk);
      if (ph == slf_pkg::SLF_PH_START)
        t.err <= err_data;
    end
  end

  // ----------------------------------------------------------------
  // lag accumulator, init and limits
  // ----------------------------------------------------------------
  logic pending;
  logic load;
  logic signed [40:0] sum;
  logic signed [32:0] sum_hi;

  assign load = pending && ph == slf_pkg::SLF_PH_START;
  assign sum = {lag_acc[39], lag_acc} + {t.lag_term[39], t.lag_term};
  assign sum_hi = sum[40:8];

  // request pending until the next compute start
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      pending <= 1'b0;
    else if (init_req)
      pending <= 1'b1;
    else if (load)
      pending <= 1'b0;
  end

  // load beats accumulate; clamp to the limits on update
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      lag_acc <= `SLF_ACC_RST;
    else if (load)
      lag_acc <= {hold_word, `SLF_ACC_FRAC_ZERO};
    else if (ph == slf_pkg::SLF_PH_UPDATE)
    begin
      if (sum_hi > $signed({upper_limit[31], upper_limit}))
        lag_acc <= {upper_limit, `SLF_ACC_FRAC_ZERO};
      else if (sum_hi < $signed({lower_limit[31], lower_limit}))
        lag_acc <= {lower_limit, `SLF_ACC_FRAC_ZERO};
      else
        lag_acc <= sum[39:0];
    end
  end

  // done flag: a load sets it, a fresh request clears it
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      lag_init_done <= 1'b0;
    else if (load && !init_req)
      lag_init_done <= 1'b1;
    else if (init_req)
      lag_init_done <= 1'b0;
  end

  // output word and host read data
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      nco_word <= 32'h00000000;
      up_rd_data <= 8'h00;
    end
    else
    begin
      if (ph == slf_pkg::SLF_PH_START)
        nco_word <= lag_acc[39:8] + t.lead_term;
      if (wa == `SLF_PORT_STATUS)
        up_rd_data <= {7'h00, lag_init_done};
      else if (wa < `SLF_PORT_DEST)
        up_rd_data <= hold[wa[1:0]];
      else
        up_rd_data <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  cycle_length_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ph == slf_pkg::SLF_PH_START |=>
    (ph != slf_pkg::SLF_PH_START) [*7] ##1
    ph == slf_pkg::SLF_PH_START)
    else $error("compute cycle is not 8 clocks");

  init_load_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    load |=> lag_acc == {$past(hold_word), 8'h00})
    else $error("lag init value wrong");

  init_wait_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    init_req |=> ##[0:7] (load && ph == slf_pkg::SLF_PH_START))
    else $error("lag init not taken within a compute cycle");

  done_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (load && !init_req) |=> lag_init_done ##1
    (up_rd_data[0] || $past(wa) != `SLF_PORT_STATUS))
    else $error("done flag not shown");

  upper_clamp_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ph == slf_pkg::SLF_PH_UPDATE && !load &&
     sum_hi > $signed({upper_limit[31], upper_limit})) |=>
    lag_acc == {$past(upper_limit), 8'h00})
    else $error("upper limit clamp wrong");

  track_gain_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (wr_evt && wa == `SLF_PORT_DEST && wd == `SLF_DEST_GAIN_TRK) |=>
    gain_trk == $past(hold_word[17:0]) ##1
    ($past(acq_mode) || t.gain == fields(gain_trk)))
    else $error("track gain not stored");

  mode_gain_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $stable(acq_mode) && $stable(gain_acq) && acq_mode |=>
    t.gain.lag_exp == $past(gain_acq[4:0]))
    else $error("acquisition gain not applied");

endmodule

/* rtl/slf_pkg.sv */
package slf_pkg;

  // compute cycle phases, one-hot
  typedef enum logic [2:0] {
    SLF_PH_START = 3'b001,
    SLF_PH_RUN = 3'b010,
    SLF_PH_UPDATE = 3'b100
  } slf_phase_e;

  // one gain set as used by the scaler
  typedef struct packed {
    logic [3:0] lead_mant;
    logic [4:0] lead_exp;
    logic [3:0] lag_mant;
    logic [4:0] lag_exp;
  } slf_gain_s;

endpackage

/* rtl/slf_term_if.sv */
`timescale 1ns/100ps
interface slf_term_if;
  logic signed [15:0] err;
  slf_pkg::slf_gain_s gain;
  logic signed [31:0] lead_term;
  logic signed [39:0] lag_term;

  modport ctrl (output err, output gain, input lead_term, input lag_term);
  modport calc (input err, input gain, output lead_term, output lag_term);
endinterface
